// *** hdl/ece_engine.sv ***
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ns
module ece_engine
  import ece_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = ECE_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_byte_in,
  output logic [7:0] port_byte_out,
  output logic port_byte_drive,
  output logic write_direction_n,
  output logic data_cycle_strobe_n,
  output logic addr_cycle_strobe_n,
  input wire logic peripheral_hold_n,
  input wire logic peripheral_irq_in,
  output logic peripheral_irq_out,
  output logic peripheral_reset_n,
  output logic host_strobe_n,
  output logic autofeed_n,
  output logic select_in_n
);
  ece_wd_if wdi ();

  ece_watchdog #(
    .LIMIT(TIMEOUT_CYC)
  ) u_wd (
    .pclk(pclk),
    .presetn(presetn),
    .wd(wdi.wd)
  );

  function automatic logic [11:0] byte_addr(input logic [3:0] idx);
    return {6'h00, idx, 2'b00};
  endfunction

  function automatic logic is_epp_port(input logic [11:0] a);
    return a >= byte_addr(ECE_IDX_EPP_ADDR) && a <= byte_addr(ECE_IDX_EPP_DATA3) && a[1:0] == 2'b00;
  endfunction

  logic [1:0] hold_sync_q;
  logic [1:0] irq_sync_q;
  logic [7:0] byte_sync0_q;
  logic [7:0] byte_sync1_q;
  logic [5:0] ctrl_q;
  logic [1:0] mode_q;
  logic [7:0] spp_data_q;
  logic [7:0] epp_addr_q;
  logic [7:0] epp_data_q;
  logic [7:0] rd_byte_q;
  logic timeout_q;
  ece_state_e state_q;
  logic cyc_read_q;
  logic cyc_addr_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [7:0] port_byte_out_q;
  logic port_byte_drive_q;
  logic write_direction_n_q;
  logic data_cycle_strobe_n_q;
  logic addr_cycle_strobe_n_q;
  logic peripheral_irq_q;
  logic [2:0] ctl_pins_q;

  logic hold_s;
  logic access;
  logic epp_sel;
  logic start;
  logic busy;
  logic to_done;
  logic wr_done;
  logic v19;
  logic cyc_in;
  logic mapped;
  logic [31:0] reg_rdata;

  assign hold_s = hold_sync_q[1];
  assign v19 = mode_q[ECE_MODE_V19_BIT];
  assign access = psel && penable && !pready_q;
  // R22 enhanced ports decode only in enhanced mode
  assign epp_sel = mode_q[ECE_MODE_EPP_BIT] && is_epp_port(paddr);
  assign start = access && epp_sel && state_q == ECE_IDLE;
  assign busy = state_q == ECE_PRE_WAIT || state_q == ECE_SETUP || state_q == ECE_STROBE;
  assign wr_done = psel && penable && pready_q && pwrite;
  // R12 older protocol: direction bit picks the transfer direction on the pins
  assign cyc_in = v19 ? cyc_read_q : ctrl_q[ECE_CTRL_DIR_BIT];
  assign mapped = paddr[1:0] == 2'b00 && paddr <= byte_addr(ECE_IDX_MODE);

  // R2 R11 R15 end only once hold is high, or on abort
  // R24 a watchdog abort still closes the access
  always_comb begin
    to_done = 1'b0;
    if (state_q == ECE_STROBE) begin
      // hold only counts once the strobe is really out
      to_done = wdi.expired || (hold_s && !(data_cycle_strobe_n_q && addr_cycle_strobe_n_q));
    end else if (state_q == ECE_PRE_WAIT) begin
      to_done = hold_s && wdi.expired;
    end
  end

  always_comb begin
    reg_rdata = 32'h0000_0000;
    case (paddr)
      byte_addr(ECE_IDX_DATA): reg_rdata = {24'h00_0000, spp_data_q};
      byte_addr(ECE_IDX_STATUS): reg_rdata = {30'h0000_0000, busy, timeout_q};
      byte_addr(ECE_IDX_CTRL): reg_rdata = {26'h000_0000, ctrl_q};
      byte_addr(ECE_IDX_MODE): reg_rdata = {30'h0000_0000, mode_q};
      default: reg_rdata = 32'h0000_0000;
    endcase
  end

  // pin inputs pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_sync_q <= 2'b11;
      irq_sync_q <= 2'b00;
      byte_sync0_q <= ECE_BYTE_RST;
      byte_sync1_q <= ECE_BYTE_RST;
    end else begin
      hold_sync_q <= {hold_sync_q[0], peripheral_hold_n};
      irq_sync_q <= {irq_sync_q[0], peripheral_irq_in};
      byte_sync0_q <= port_byte_in;
      byte_sync1_q <= byte_sync0_q;
    end
  end

  // cycle sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ECE_IDLE;
      cyc_read_q <= 1'b0;
      cyc_addr_q <= 1'b0;
    end else begin
      case (state_q)
        ECE_IDLE: begin
          if (start) begin
            cyc_read_q <= !pwrite;
            cyc_addr_q <= paddr == byte_addr(ECE_IDX_EPP_ADDR);
            // R3 newer protocol waits for hold low first
            state_q <= (v19 && hold_s) ? ECE_PRE_WAIT : ECE_SETUP;
          end
        end
        ECE_PRE_WAIT: begin
          if (!hold_s) begin
            state_q <= ECE_SETUP;
          end else if (to_done) begin
            state_q <= ECE_DONE;
          end
        end
        ECE_SETUP: state_q <= ECE_STROBE;
        ECE_STROBE: begin
          // R1 access stays stretched until here
          if (to_done) begin
            state_q <= ECE_DONE;
          end
        end
        ECE_DONE: state_q <= ECE_IDLE;
        default: state_q <= ECE_IDLE;
      endcase
    end
  end

  assign wdi.restart = start;
  assign wdi.run = busy;

  // R9 timeout flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_q <= 1'b0;
    end else if (busy && wdi.expired) begin
      timeout_q <= 1'b1;
    end else if (wr_done && paddr == byte_addr(ECE_IDX_STATUS) && pwdata[ECE_STAT_TMO_BIT]) begin
      timeout_q <= 1'b0;
    end
  end

  // R10 software presets control bits; writes land only on completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ECE_CTRL_RST;
      mode_q <= ECE_MODE_RST;
    end else if (wr_done) begin
      if (paddr == byte_addr(ECE_IDX_CTRL)) begin
        ctrl_q <= pwdata[5:0];
      end
      if (paddr == byte_addr(ECE_IDX_MODE)) begin
        mode_q <= pwdata[1:0];
      end
    end
  end

  // address and data port registers hold the last write cycle's byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      epp_addr_q <= ECE_BYTE_RST;
      epp_data_q <= ECE_BYTE_RST;
      spp_data_q <= ECE_BYTE_RST;
    end else begin
      if (start && pwrite && paddr == byte_addr(ECE_IDX_EPP_ADDR)) begin
        epp_addr_q <= pwdata[7:0];
      end else if (start && pwrite) begin
        epp_data_q <= pwdata[7:0];
      end
      if (wr_done && paddr == byte_addr(ECE_IDX_DATA)) begin
        spp_data_q <= pwdata[7:0];
      end
    end
  end

  // R6 capture byte bus at termination
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_byte_q <= ECE_BYTE_RST;
    end else if (to_done && cyc_in) begin
      rd_byte_q <= byte_sync1_q;
    end
  end

  // bus answer: one cycle for plain registers, end of cycle for port ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= (access && !epp_sel) || to_done;
      pslverr_q <= access && !epp_sel && !mapped;
      if (access && !epp_sel) begin
        prdata_q <= reg_rdata;
      end else if (to_done) begin
        // R6 answer carries the captured byte
        prdata_q <= {24'h00_0000, cyc_in ? byte_sync1_q : 8'h00};
      end
    end
  end

  // R21 strobe per cycle kind; R16 R14 negate on termination
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_cycle_strobe_n_q <= 1'b1;
      addr_cycle_strobe_n_q <= 1'b1;
    end else if (state_q == ECE_STROBE && data_cycle_strobe_n_q && addr_cycle_strobe_n_q && !to_done) begin
      data_cycle_strobe_n_q <= cyc_addr_q;
      addr_cycle_strobe_n_q <= !cyc_addr_q;
    end else if (state_q != ECE_STROBE || to_done) begin
      data_cycle_strobe_n_q <= 1'b1;
      addr_cycle_strobe_n_q <= 1'b1;
    end
  end

  // byte bus and write direction; bus set up one cycle before the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_byte_out_q <= ECE_BYTE_RST;
      port_byte_drive_q <= 1'b0;
      write_direction_n_q <= 1'b1;
    end else if (state_q == ECE_SETUP) begin
      // R4 R13 float for reads unless the control strobe bit is set, drive byte for writes
      port_byte_drive_q <= !cyc_in || ctrl_q[ECE_CTRL_STB_BIT];
      // R19 control strobe bit forces write direction
      write_direction_n_q <= cyc_in && !ctrl_q[ECE_CTRL_STB_BIT];
      if (!cyc_read_q) begin
        port_byte_out_q <= cyc_addr_q ? epp_addr_q : epp_data_q;
      end
    end else if (!busy) begin
      // R8 R23 plain port: direction bit steers the bus
      port_byte_drive_q <= !ctrl_q[ECE_CTRL_DIR_BIT];
      // R12 older protocol direction bit drives write direction
      write_direction_n_q <= !(mode_q[ECE_MODE_EPP_BIT] && !v19) || ctrl_q[ECE_CTRL_DIR_BIT];
      if (wr_done && paddr == byte_addr(ECE_IDX_DATA)) begin
        port_byte_out_q <= pwdata[7:0];
      end
    end
  end

  // R17 R18 interrupt pass-through and control pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_q <= 1'b0;
      ctl_pins_q <= 3'h7;
      peripheral_reset_n <= 1'b0;
    end else begin
      peripheral_irq_q <= irq_sync_q[1];
      ctl_pins_q <= ~{ctrl_q[ECE_CTRL_SLIN_BIT], ctrl_q[ECE_CTRL_AFD_BIT], ctrl_q[ECE_CTRL_STB_BIT]};
      peripheral_reset_n <= ctrl_q[ECE_CTRL_INIT_BIT];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign port_byte_out = port_byte_out_q;
  assign port_byte_drive = port_byte_drive_q;
  assign write_direction_n = write_direction_n_q;
  assign data_cycle_strobe_n = data_cycle_strobe_n_q;
  assign addr_cycle_strobe_n = addr_cycle_strobe_n_q;
  assign peripheral_irq_out = peripheral_irq_q;
  assign host_strobe_n = ctl_pins_q[0];
  assign autofeed_n = ctl_pins_q[1];
  assign select_in_n = ctl_pins_q[2];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_strobe_exclusive: assert property (data_cycle_strobe_n || addr_cycle_strobe_n) // R21
    else $error("both strobes active");
  a_read_bus_float: assert property (
    (!data_cycle_strobe_n || !addr_cycle_strobe_n) && cyc_in && !ctrl_q[ECE_CTRL_STB_BIT] |-> !port_byte_drive) // R4
    else $error("bus driven during read strobe");
  a_prewait_no_strobe: assert property (
    state_q == ECE_PRE_WAIT |-> data_cycle_strobe_n && addr_cycle_strobe_n && $stable(write_direction_n)) // R3
    else $error("pins changed before hold went low");
  a_end_needs_hold: assert property (
    state_q == ECE_STROBE && !hold_s && !wdi.expired |=> state_q == ECE_STROBE && !pready) // R2
    else $error("cycle ended while hold low");
  a_timeout_flag: assert property (busy && wdi.expired |=> timeout_q) // R9
    else $error("timeout not flagged");
  a_abort_answers: assert property (state_q == ECE_STROBE && wdi.expired |=> pready ##1 state_q == ECE_IDLE) // R24
    else $error("aborted cycle left bus hanging");
  a_done_strobe_off: assert property (pready && state_q == ECE_DONE |-> data_cycle_strobe_n && addr_cycle_strobe_n) // R6
    else $error("strobe active at answer");
  a_read_byte_back: assert property (
    to_done && cyc_in |=> prdata[7:0] == $past(byte_sync1_q) && rd_byte_q == prdata[7:0]) // R6
    else $error("read byte not returned");
  a_irq_passthru: assert property (peripheral_irq_out == $past(peripheral_irq_in, 3)) // R17
    else $error("interrupt not passed through");
  a_idle_direction: assert property (
    state_q == ECE_IDLE && $past(state_q) == ECE_IDLE |=> port_byte_drive == !$past(ctrl_q[ECE_CTRL_DIR_BIT])) // R23
    else $error("idle bus direction wrong");
  a_stretch_access: assert property (start |-> !pready ##1 !pready ##1 !pready) // R1
    else $error("access answered too early");

  c_new_read: cover property (v19 && start && !pwrite ##[1:40] pready);
  c_old_write: cover property (!v19 && start && pwrite ##[1:40] pready);
  c_timeout: cover property (busy && wdi.expired);
  c_prewait: cover property (state_q == ECE_PRE_WAIT ##[1:20] state_q == ECE_SETUP);
endmodule // ece_engine

// *** hdl/ece_pkg.sv ***
// Function
// R1: newer protocol read stretches the bus access until the port read can end
// R2: hold already low at strobe: read ends only after hold returns high
// R3: hold high at newer read start: wait for low before direction or strobe
// R4: newer read floats the byte bus, negates write direction, then strobes
// R5: peripheral drives valid data, then raises hold to allow termination
// R6: termination captures byte, negates strobe, answers bus with that byte
// R7: after strobe negates peripheral floats bus and pulls hold low
// R8: outside cycles the byte bus is a plain port steered by control register
// R9: older protocol cycles over 10 us are aborted and set status bit 0
// R10: software clears control bits 0,1,3 and sets direction per transfer
// R11: older write waits while hold low, ends when high or on timeout
// R12: older protocol direction bit high floats bus, low asserts write direction
// R13: older write drives the byte, then asserts address or data strobe
// R14: older write ends with bus answer, strobe negated, byte kept on bus
// R15: older read waits while hold low, completes once hold is high
// R16: older read ends with bus answer, then negates the active strobe
// R17: peripheral interrupt passes through as active high, not inverted
// R18: active low peripheral reset output returns peripheral to initial mode
// R19: only write direction may be overridden by control register during cycles; the code's strobe bit also forces the byte bus driven
// R20: peripheral raises hold when done, lowers it when ready for next
// R21: address strobe for address cycles, data strobe for data, direction for writes
// R22: address port at index 3, data ports 4 to 7, only in enhanced mode
// R23: direction bit zero means output, one means input
// R24: a watchdog abort still answers the pending bus access
// R25: watchdog counts system clocks, restarts per cycle, compares to constant
package ece_pkg;
  localparam int unsigned ECE_CLK_NS = 10;
  localparam int unsigned ECE_TIMEOUT_NS = 10000;
  // longest time: rounds down
  localparam int unsigned ECE_TIMEOUT_CYC = ECE_TIMEOUT_NS / ECE_CLK_NS;
  localparam logic [3:0] ECE_IDX_DATA = 4'h0;
  localparam logic [3:0] ECE_IDX_STATUS = 4'h1;
  localparam logic [3:0] ECE_IDX_CTRL = 4'h2;
  localparam logic [3:0] ECE_IDX_EPP_ADDR = 4'h3;
  localparam logic [3:0] ECE_IDX_EPP_DATA0 = 4'h4;
  localparam logic [3:0] ECE_IDX_EPP_DATA3 = 4'h7;
  localparam logic [3:0] ECE_IDX_MODE = 4'h8;
  localparam int ECE_STAT_TMO_BIT = 0;
  localparam int ECE_STAT_BUSY_BIT = 1;
  localparam int ECE_CTRL_STB_BIT = 0;
  localparam int ECE_CTRL_AFD_BIT = 1;
  localparam int ECE_CTRL_INIT_BIT = 2;
  localparam int ECE_CTRL_SLIN_BIT = 3;
  localparam int ECE_CTRL_DIR_BIT = 5;
  localparam logic [5:0] ECE_CTRL_RST = 6'h00;
  localparam int ECE_MODE_EPP_BIT = 0;
  localparam int ECE_MODE_V19_BIT = 1;
  localparam logic [1:0] ECE_MODE_RST = 2'h0;
  localparam logic [7:0] ECE_BYTE_RST = 8'h00;
  typedef enum logic [2:0] {
    ECE_IDLE,
    ECE_PRE_WAIT,
    ECE_SETUP,
    ECE_STROBE,
    ECE_DONE
  } ece_state_e;
endpackage

// *** hdl/ece_watchdog.sv ***
`timescale 1ns/1ns
module ece_watchdog
  import ece_pkg::*;
#(
  parameter int unsigned LIMIT = ECE_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  ece_wd_if.wd wd
);
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt_q;
  logic expired_q;

  // R25 restartable cycle counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (wd.restart) begin
      cnt_q <= '0;
    end else if (wd.run && cnt_q != W'(LIMIT)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expired_q <= 1'b0;
    end else begin
      expired_q <= wd.run && !wd.restart && cnt_q >= W'(LIMIT - 1);
    end
  end

  assign wd.expired = expired_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wd_limit: assert property (wd.expired |-> $past(cnt_q) >= W'(LIMIT - 1)) // R25
    else $error("watchdog expired early");
  a_wd_restart: assert property (wd.restart |=> cnt_q == '0 && !wd.expired) // R25
    else $error("watchdog not restarted");
endmodule // ece_watchdog

// *** hdl/ece_wd_if.sv ***
`timescale 1ns/1ns
interface ece_wd_if;
  logic restart;
  logic run;
  logic expired;
  modport eng (output restart, output run, input expired);
  modport wd (input restart, input run, output expired);
endinterface

// *** test/ece_periph_model.sv ***
`timescale 1ns/1ns
module ece_periph_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] host_byte,
  input wire logic host_drive,
  input wire logic write_direction_n,
  input wire logic data_cycle_strobe_n,
  input wire logic addr_cycle_strobe_n,
  input wire logic [7:0] rd_byte,
  input wire logic [3:0] dly,
  input wire logic stuck,
  input wire logic pre_high,
  output logic [7:0] port_byte_lines,
  output logic peripheral_hold_n,
  output logic [7:0] got_byte,
  output logic got_addr
);
  logic [3:0] cnt_q;
  logic hold_q;
  logic drv_q;
  logic [7:0] last_q = 8'h00;
  logic stb;
  assign stb = ~data_cycle_strobe_n | ~addr_cycle_strobe_n;
  // released lines toggle, so a stale byte never passes for data
  assign port_byte_lines = host_drive ? host_byte : (drv_q ? rd_byte : ~last_q);
  assign peripheral_hold_n = pre_high | hold_q;
  always_ff @(posedge pclk) begin
    last_q <= port_byte_lines;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      hold_q <= 1'b0;
      drv_q <= 1'b0;
      got_byte <= 8'h00;
      got_addr <= 1'b0;
    end else if (!stb) begin
      cnt_q <= 4'h0;
      hold_q <= 1'b0;
      drv_q <= 1'b0;
    end else if (!hold_q && !stuck) begin
      drv_q <= write_direction_n;
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == dly) begin
        hold_q <= 1'b1;
        got_byte <= port_byte_lines;
        got_addr <= ~addr_cycle_strobe_n;
      end
    end
  end
endmodule // ece_periph_model

// *** test/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  localparam int TMO = 40;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] port_byte_lines;
  logic [7:0] port_byte_out;
  logic port_byte_drive;
  logic write_direction_n;
  logic data_cycle_strobe_n;
  logic addr_cycle_strobe_n;
  logic peripheral_hold_n;
  logic peripheral_irq_in = 1'b0;
  logic peripheral_irq_out;
  logic peripheral_reset_n;
  logic host_strobe_n;
  logic autofeed_n;
  logic select_in_n;
  logic [7:0] rd_byte = 8'h00;
  logic [3:0] dly = 4'h2;
  logic stuck = 1'b0;
  logic pre_high = 1'b0;
  logic rd_mon = 1'b0;
  logic [7:0] got_byte;
  logic got_addr;
  int err_count = 0;
  int checks = 0;
  always #5 pclk = ~pclk;
  ece_engine #(.TIMEOUT_CYC(TMO)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_byte_in(port_byte_lines), .port_byte_out(port_byte_out),
    .port_byte_drive(port_byte_drive), .write_direction_n(write_direction_n),
    .data_cycle_strobe_n(data_cycle_strobe_n), .addr_cycle_strobe_n(addr_cycle_strobe_n),
    .peripheral_hold_n(peripheral_hold_n), .peripheral_irq_in(peripheral_irq_in),
    .peripheral_irq_out(peripheral_irq_out), .peripheral_reset_n(peripheral_reset_n),
    .host_strobe_n(host_strobe_n), .autofeed_n(autofeed_n), .select_in_n(select_in_n));
  ece_periph_model periph (.pclk(pclk), .presetn(presetn), .host_byte(port_byte_out),
    .host_drive(port_byte_drive), .write_direction_n(write_direction_n),
    .data_cycle_strobe_n(data_cycle_strobe_n), .addr_cycle_strobe_n(addr_cycle_strobe_n),
    .rd_byte(rd_byte), .dly(dly), .stuck(stuck), .pre_high(pre_high),
    .port_byte_lines(port_byte_lines), .peripheral_hold_n(peripheral_hold_n),
    .got_byte(got_byte), .got_addr(got_addr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // n counts access edges until pready; the bench watchdog ends a hang
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r, output logic e, output int n);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // look before the edge so the answer flop's own edge is never raced
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    int n;
    apb(a, 1'b1, d, r, e, n);
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  always @(negedge pclk) begin
    if (rd_mon && !(data_cycle_strobe_n && addr_cycle_strobe_n)) begin
      chk({port_byte_drive, write_direction_n}, 2'b01); // floated while strobed
    end
  end
  initial begin
    #300000;
    err_count++;
    results();
  end
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    repeat (11) @(posedge pclk);
    chk({peripheral_reset_n, data_cycle_strobe_n, addr_cycle_strobe_n}, 3'b011); // in reset
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(12'h024, 1'b0, 32'h0, r, e, n);
    chk({e, r[7:0]}, 9'h100); // unmapped place
    apb(12'h010, 1'b0, 32'h0, r, e, n);
    chk({e, r[7:0], data_cycle_strobe_n}, 10'h001); // port off outside enhanced mode
    wr(12'h008, 32'h0b);
    settle();
    chk({peripheral_reset_n, host_strobe_n, autofeed_n, select_in_n}, 4'h0); // plain control
    wr(12'h008, 32'h04);
    wr(12'h020, 32'h1);
    settle();
    chk({peripheral_reset_n, host_strobe_n, autofeed_n, select_in_n}, 4'hf); // released
    chk({write_direction_n, port_byte_drive}, 2'b01); // output mode
    wr(12'h00c, 32'ha5);
    settle();
    chk({got_addr, got_byte}, 9'h1a5); // address write
    chk({port_byte_out, port_byte_drive, addr_cycle_strobe_n}, 10'h297); // byte kept
    for (int i = 0; i < 4; i++) begin
      wr(12'h010 + 12'(4 * i), 32'h10 + i);
      settle();
      chk({got_addr, got_byte}, 9'h010 + i); // data ports
    end
    wr(12'h008, 32'h24);
    settle();
    chk({write_direction_n, port_byte_drive}, 2'b10); // input mode
    rd_byte <= 8'h3c;
    dly <= 4'h4;
    apb(12'h014, 1'b0, 32'h0, r, e, n);
    chk(r, 32'h3c); // older data read
    chk({got_addr, n >= 7}, 2'b01); // waits for hold
    rd_byte <= 8'h5a;
    apb(12'h00c, 1'b0, 32'h0, r, e, n);
    chk({r[7:0], got_addr}, 9'hb5); // address read
    wr(12'h008, 32'h25);
    fork
      apb(12'h014, 1'b0, 32'h0, r, e, n);
      begin
        repeat (6) @(posedge pclk);
        #1;
        chk({write_direction_n, port_byte_drive, data_cycle_strobe_n}, 3'b010); // strobe bit forces write
      end
    join
    chk(r, 32'h13); // forced bus reads its own byte
    wr(12'h008, 32'h04);
    stuck <= 1'b1;
    apb(12'h018, 1'b1, 32'h77, r, e, n);
    chk(n >= TMO && n <= TMO + 6, 1); // abort bound
    settle();
    chk({data_cycle_strobe_n, addr_cycle_strobe_n}, 2'b11); // strobe off
    stuck <= 1'b0;
    apb(12'h004, 1'b0, 32'h0, r, e, n);
    chk(r[0], 1'b1); // timeout flag
    wr(12'h004, 32'h1);
    apb(12'h004, 1'b0, 32'h0, r, e, n);
    chk(r[0], 1'b0); // flag cleared
    wr(12'h020, 32'h3);
    pre_high <= 1'b1;
    rd_byte <= 8'hc3;
    dly <= 4'h2;
    rd_mon <= 1'b1;
    fork
      apb(12'h010, 1'b0, 32'h0, r, e, n);
      begin
        repeat (12) @(posedge pclk);
        chk({data_cycle_strobe_n, addr_cycle_strobe_n, write_direction_n}, 3'b111); // held off
        pre_high <= 1'b0;
      end
    join
    chk(r, 32'hc3); // newer read
    rd_byte <= 8'h96;
    dly <= 4'h5;
    apb(12'h00c, 1'b0, 32'h0, r, e, n);
    chk({r[7:0], got_addr}, 9'h12d); // hold low at strobe
    rd_mon <= 1'b0;
    peripheral_irq_in <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
    chk(peripheral_irq_out, 1'b1); // passed through
    peripheral_irq_in <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    chk(peripheral_irq_out, 1'b0); // follows low
    results();
  end
endmodule // testbench
